// >>> verilog/ppg_cfg_regs.sv
/*
 * Configuration and status of the pattern test unit: generator state
 * pages behind an indirect window, payload concatenation for generator
 * and monitor, byte-error and sync-change interrupt flags, APB slave.
 * Assumes the generator and monitor run on pclk, so their signals need
 * no synchroniser, and that software polls no busy flag.
 */
// What this block does
// - Page 9h shows and loads LFSR bits 22..7 of the selected path.
// - Page Ah shows and loads LFSR bits 6..0; bits 15..7 read zero.
// - Generator triple bit k groups paths k+1, k+5, k+9 as one payload.
// - Generator full bit 14 makes paths 1..12 one payload, beating triples.
// - Generator settings drive the protect-link pattern generator.
// - Monitor triple bit k groups paths k+1, k+5, k+9 as one payload.
// - Monitor full bit 14 makes paths 1..12 one payload, beating triples.
// - Monitor settings drive the protection-link pattern monitor.
// - Byte-error flag of path x at bit x-1, set on error while in sync.
// - Byte-error flags set regardless of enables, clear on read.
// - Byte-error enable bit x-1 lets path x flag raise the interrupt.
// - Sync-change flag register covers 12 paths, path x at bit x-1.
// - Sync-change flag sets on any sync transition, clears on read.
`timescale 1ns/10ps
`include "ppg_cfg.svh"


module ppg_cfg_regs
    import ppg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    input wire logic [`PPG_PATH_W-1:0] gen_rd_path,
    output logic [`PPG_LFSR_W-1:0] gen_rd_state,
    output logic gen_rd_lead,
    input wire ppg_lfsr_upd_t gen_upd,
    output ppg_concat_cfg_t gen_concat_cfg,
    output logic [`PPG_NUM_PATHS-1:0] gen_concat_vec,
    output ppg_concat_cfg_t mon_concat_cfg,
    output logic [`PPG_NUM_PATHS-1:0] mon_lead_vec,
    output logic [`PPG_NUM_PATHS-1:0] mon_concat_vec,
    input wire logic [`PPG_NUM_PATHS-1:0] mon_sync,
    input wire logic [`PPG_NUM_PATHS-1:0] mon_byte_err
);

    localparam int NP = `PPG_NUM_PATHS;

    // ============================================================
    // Elaboration checks: the status and page layouts assume these sizes
    // Other path counts would need new status words and a new select map
    if (NP != 12)
    begin : g_bad_paths
        $error("ppg_cfg_regs: status words are laid out for twelve paths");
    end
    if (`PPG_HIGH_W + `PPG_LOW_W != `PPG_LFSR_W)
    begin : g_bad_split
        $error("ppg_cfg_regs: the two pages must cover the whole state");
    end
    if (NP > (1 << `PPG_PATH_W))
    begin : g_bad_path_w
        $error("ppg_cfg_regs: path field too narrow for the path count");
    end

    // ============================================================
    // Register state
    logic [7:0] sel_q;
    logic [15:0] gen_cfg_q;
    logic [15:0] mon_cfg_q;
    logic [NP-1:0] err_en_q;
    logic [NP-1:0] sync_en_q;
    logic [`PPG_LFSR_W-1:0] lfsr_q [NP];
    logic [31:0] prdata_q;
    logic [NP-1:0] mon_sync_q;
    logic primed_q;
    logic [`PPG_LFSR_W-1:0] gen_rd_state_q;
    logic gen_rd_lead_q;

    // ============================================================
    // Bus decode
    logic [9:0] idx;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic hit_sel;
    logic hit_data;
    logic hit_gen;
    logic hit_mon;
    logic hit_err_stat;
    logic hit_err_en;
    logic hit_sync_stat;
    logic hit_sync_en;
    logic mapped;

    assign idx = paddr[11:2];
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit_sel = (idx == `PPG_IDX_SEL);
    assign hit_data = (idx == `PPG_IDX_DATA);
    assign hit_gen = (idx == `PPG_IDX_GEN_CFG);
    assign hit_mon = (idx == `PPG_IDX_MON_CFG);
    assign hit_err_stat = (idx == `PPG_IDX_ERR_STAT);
    assign hit_err_en = (idx == `PPG_IDX_ERR_EN);
    assign hit_sync_stat = (idx == `PPG_IDX_SYNC_STAT);
    assign hit_sync_en = (idx == `PPG_IDX_SYNC_EN);
    assign mapped = hit_sel | hit_data | hit_gen | hit_mon | hit_err_stat
                  | hit_err_en | hit_sync_stat | hit_sync_en;
    assign wr = access & pwrite & mapped;
    assign rd = access & ~pwrite & mapped;

    // Zero wait states: read data is captured in the setup cycle
    assign pready = access;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_q;

    // ============================================================
    // Indirect window selection
    logic [3:0] sel_page;
    logic [`PPG_PATH_W-1:0] sel_path;
    logic sel_ok;
    logic [`PPG_LFSR_W-1:0] sel_state;
    logic page_high;
    logic page_low;

    assign sel_page = sel_q[`PPG_SEL_PAGE_LSB +: 4];
    assign sel_path = sel_q[`PPG_SEL_PATH_LSB +: `PPG_PATH_W];
    // Paths beyond the twelfth read zero and ignore writes
    assign sel_ok = (sel_path < `PPG_PATH_W'(NP));
    assign sel_state = sel_ok ? lfsr_q[sel_path] : '0;
    assign page_high = sel_ok && (sel_page == `PPG_PAGE_GEN_HIGH);
    assign page_low = sel_ok && (sel_page == `PPG_PAGE_GEN_LOW);

    logic [15:0] data_word;
    assign data_word =
        page_high ? sel_state[`PPG_LFSR_W-1:`PPG_LOW_W] :
        page_low ? {9'h000, sel_state[`PPG_LOW_W-1:0]} :
        16'h0000;

    // ============================================================
    // Payload concatenation decode
    logic [3:0] gen_master;
    logic gen_path_ok;
    logic [NP-1:0] gen_lead_vec;

    // Whole-struct assignment keeps each output to one driver
    assign gen_concat_cfg = {
        gen_cfg_q[`PPG_FULL_BIT],
        gen_cfg_q[`PPG_TRIPLE_LSB +: `PPG_TRIPLE_W]
    };
    assign mon_concat_cfg = {
        mon_cfg_q[`PPG_FULL_BIT],
        mon_cfg_q[`PPG_TRIPLE_LSB +: `PPG_TRIPLE_W]
    };

    ppg_concat_map u_gen_map (
        .cfg(gen_concat_cfg),
        .query(gen_rd_path),
        .lead_vec(gen_lead_vec),
        .concat_vec(gen_concat_vec),
        .query_master(gen_master)
    );

    // Monitor has no state pages here, so its query is unused
    ppg_concat_map u_mon_map (
        .cfg(mon_concat_cfg),
        .query(`PPG_PATH_W'(0)),
        .lead_vec(mon_lead_vec),
        .concat_vec(mon_concat_vec),
        .query_master()
    );

    assign gen_path_ok = (gen_rd_path < `PPG_PATH_W'(NP));

    // ============================================================
    // Interrupt flags
    logic [NP-1:0] err_flags;
    logic [NP-1:0] sync_flags;
    logic [NP-1:0] err_set;
    logic [NP-1:0] sync_set;
    logic [NP-1:0] err_clr;
    logic [NP-1:0] sync_clr;

    assign err_set = mon_byte_err & mon_sync;
    // First cycle after reset has no valid previous sync level
    assign sync_set = primed_q ? (mon_sync ^ mon_sync_q) : '0;
    // Clear only what the reader was shown in the setup cycle
    assign err_clr = (rd && hit_err_stat) ?
        prdata_q[NP-1:0] : '0;
    assign sync_clr = (rd && hit_sync_stat) ?
        prdata_q[NP-1:0] : '0;

    ppg_event_flags #(
        .WIDTH(NP)
    ) u_err_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(err_set),
        .clr_i(err_clr),
        .flags(err_flags)
    );

    ppg_event_flags #(
        .WIDTH(NP)
    ) u_sync_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(sync_set),
        .clr_i(sync_clr),
        .flags(sync_flags)
    );

    logic err_irq;
    logic sync_irq;
    assign err_irq = |(err_flags & err_en_q);
    assign sync_irq = |(sync_flags & sync_en_q);
    assign irq = err_irq | sync_irq;

    // ============================================================
    // Read mux
    logic [15:0] rd_word;
    assign rd_word =
        hit_sel ? {8'h00, sel_q} :
        hit_data ? data_word :
        hit_gen ? gen_cfg_q :
        hit_mon ? mon_cfg_q :
        hit_err_stat ? {4'h0, err_flags} :
        hit_err_en ? {4'h0, err_en_q} :
        hit_sync_stat ? {4'h0, sync_flags} :
        hit_sync_en ? {4'h0, sync_en_q} :
        16'h0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (setup)
            prdata_q <= {16'h0000, rd_word};
    end

    // ============================================================
    // Software writable registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_q <= `PPG_SEL_RST;
            gen_cfg_q <= `PPG_CFG_RST;
            mon_cfg_q <= `PPG_CFG_RST;
            err_en_q <= '0;
            sync_en_q <= '0;
        end
        else if (wr)
        begin
            if (hit_sel)
                sel_q <= pwdata[7:0];
            if (hit_gen)
                gen_cfg_q <=
                    pwdata[15:0] & `PPG_GEN_CFG_WMASK;
            if (hit_mon)
                mon_cfg_q <=
                    pwdata[15:0] & `PPG_MON_CFG_WMASK;
            if (hit_err_en)
                err_en_q <= pwdata[NP-1:0];
            if (hit_sync_en)
                sync_en_q <= pwdata[NP-1:0];
        end
    end

    // ============================================================
    // Generator LFSR state per path; a software load wins over the
    // generator's own update of the same path in the same cycle
    logic sw_load;
    assign sw_load = wr && hit_data && (page_high || page_low);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NP; i++)
                lfsr_q[i] <= `PPG_LFSR_RST;
        end
        else
        begin
            if (gen_upd.valid && gen_upd.path < `PPG_PATH_W'(NP))
                lfsr_q[gen_upd.path] <= gen_upd.state;
            if (sw_load && page_high)
                lfsr_q[sel_path][`PPG_LFSR_W-1:`PPG_LOW_W] <=
                    pwdata[`PPG_HIGH_W-1:0];
            if (sw_load && page_low)
                lfsr_q[sel_path][`PPG_LOW_W-1:0] <=
                    pwdata[`PPG_LOW_W-1:0];
        end
    end

    // ============================================================
    // Generator lookup: a concatenated path reads its first path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_rd_state_q <= `PPG_LFSR_RST;
            gen_rd_lead_q <= 1'b0;
        end
        else
        begin
            gen_rd_state_q <=
                gen_path_ok ? lfsr_q[gen_master] : '0;
            gen_rd_lead_q <= gen_path_ok && gen_lead_vec[gen_rd_path];
        end
    end

    assign gen_rd_state = gen_rd_state_q;
    assign gen_rd_lead = gen_rd_lead_q;

    // ============================================================
    // Previous sync level for change detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mon_sync_q <= '0;
            primed_q <= 1'b0;
        end
        else
        begin
            mon_sync_q <= mon_sync;
            primed_q <= 1'b1;
        end
    end

endmodule

// >>> verilog/ppg_cfg.svh
/*
 * Constants of the pattern test unit configuration block: register
 * indices, field positions, widths and reset values.
 * Assumes it is included by its bare name and defines nothing else.
 */
`ifndef PPG_CFG_SVH
`define PPG_CFG_SVH

// ============================================================
// Sizes
`define PPG_NUM_PATHS 12
`define PPG_PATH_W 4
`define PPG_LFSR_W 23
`define PPG_HIGH_W 16
`define PPG_LOW_W 7
`define PPG_TRIPLE_W 4

// ============================================================
// Register indices; byte address is four times the index
`define PPG_IDX_SEL 10'h080
`define PPG_IDX_DATA 10'h081
`define PPG_IDX_GEN_CFG 10'h082
`define PPG_IDX_MON_CFG 10'h083
`define PPG_IDX_ERR_STAT 10'h084
`define PPG_IDX_ERR_EN 10'h085
`define PPG_IDX_SYNC_STAT 10'h089
`define PPG_IDX_SYNC_EN 10'h08A

// ============================================================
// Fields
`define PPG_PAGE_GEN_HIGH 4'h9
`define PPG_PAGE_GEN_LOW 4'hA
`define PPG_SEL_PAGE_LSB 0
`define PPG_SEL_PATH_LSB 4
`define PPG_FULL_BIT 14
`define PPG_TRIPLE_LSB 0
`define PPG_GEN_CFG_WMASK 16'hC70F
`define PPG_MON_CFG_WMASK 16'hC74F

// ============================================================
// Reset values
`define PPG_CFG_RST 16'h0000
`define PPG_SEL_RST 8'h00
`define PPG_LFSR_RST 23'h000000

`endif

// >>> verilog/ppg_pkg.sv
/*
 * Types shared by the pattern test unit configuration block.
 * Assumes ppg_cfg.svh is on the include path.
 */
`include "ppg_cfg.svh"

package ppg_pkg;

    // ============================================================
    // Payload concatenation setting as seen by generator or monitor
    typedef struct packed {
        logic full;
        logic [`PPG_TRIPLE_W-1:0] triple;
    } ppg_concat_cfg_t;

    // ============================================================
    // State written back by the generator after it advances a path
    typedef struct packed {
        logic valid;
        logic [`PPG_PATH_W-1:0] path;
        logic [`PPG_LFSR_W-1:0] state;
    } ppg_lfsr_upd_t;

endpackage

// >>> verilog/ppg_event_flags.sv
/*
 * Sticky event flags, one per path.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/10ps

module ppg_event_flags #(
    parameter int WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("ppg_event_flags: WIDTH must be at least 1");
    end

    // Set beats clear so an event in the clearing cycle survives
    assign flags_d = (flags_q & ~clr_i) | set_i;
    assign flags = flags_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

endmodule

// >>> verilog/ppg_concat_map.sv
/*
 * Maps a payload concatenation setting onto the twelve paths.
 * Purely combinational; assumes a valid path on the query.
 */
`timescale 1ns/10ps
`include "ppg_cfg.svh"

module ppg_concat_map
    import ppg_pkg::*;
(
    input wire ppg_concat_cfg_t cfg,
    input wire logic [`PPG_PATH_W-1:0] query,
    output logic [`PPG_NUM_PATHS-1:0] lead_vec,
    output logic [`PPG_NUM_PATHS-1:0] concat_vec,
    output logic [`PPG_PATH_W-1:0] query_master
);

    // ============================================================
    // Per path: group k holds paths k, k+4, k+8 (zero based)
    for (genvar p = 0; p < `PPG_NUM_PATHS; p++)
    begin : g_path
        localparam int GRP = p % `PPG_TRIPLE_W;
        assign concat_vec[p] = cfg.full | cfg.triple[GRP];
        assign lead_vec[p] = cfg.full ? (p == 0) :
            (!cfg.triple[GRP] || p < `PPG_TRIPLE_W);
    end

    // ============================================================
    // First path of the payload that owns the queried path
    assign query_master = cfg.full ? '0 :
                          cfg.triple[query[1:0]] ? {2'b00, query[1:0]} :
                          query;

endmodule

// >>> testbench/ppg_cfg_sva.sv
/*
 * Concurrent checks on the ports of ppg_cfg_regs.
 * Assumes one clock domain, pclk, with presetn as its reset.
 */
`timescale 1ns/10ps

module ppg_cfg_sva
    import ppg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [3:0] gen_rd_path,
    input wire logic gen_rd_lead,
    input wire ppg_concat_cfg_t gen_concat_cfg,
    input wire logic [11:0] gen_concat_vec,
    input wire ppg_concat_cfg_t mon_concat_cfg,
    input wire logic [11:0] mon_lead_vec,
    input wire logic [11:0] mon_concat_vec
);
    // ============================================================
    // Address decode
    wire [9:0] idx_w;
    wire mapped_w;
    assign idx_w = paddr[11:2];
    assign mapped_w = (idx_w inside {10'h080, 10'h081, 10'h082, 10'h083,
        10'h084, 10'h085, 10'h089, 10'h08A});

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ============================================================
    // Bus, map and post-reset interrupt checks
    ready_phase_a: assert property (pready == (psel && penable))
        else $error("pready does not follow the access phase");
    bad_index_a: assert property (psel && penable && !mapped_w |-> pslverr)
        else $error("unmapped index without error");
    err_phase_a: assert property (pslverr |-> psel && penable && !mapped_w)
        else $error("error response out of place");
    bad_data_a: assert property (psel && penable && !pwrite && !mapped_w
        |-> prdata == 32'h00000000)
        else $error("unmapped read returns data");
    gen_group_a:
        assert property (gen_concat_vec ==
            ({12{gen_concat_cfg.full}} | {3{gen_concat_cfg.triple}}))
        else $error("generator grouping vector wrong");
    mon_group_a:
        assert property (mon_concat_vec ==
            ({12{mon_concat_cfg.full}} | {3{mon_concat_cfg.triple}}))
        else $error("monitor grouping vector wrong");
    mon_full_lead_a:
        assert property (mon_concat_cfg.full |-> mon_lead_vec == 12'h001)
        else $error("full concatenation has extra leaders");
    gen_follow_a:
        assert property (gen_concat_cfg.full && gen_rd_path inside {[1:11]}
            |=> !gen_rd_lead)
        else $error("follower path reported as leader");
    gen_alone_a:
        assert property (!gen_concat_cfg.full && gen_concat_cfg.triple == 4'h0
            && gen_rd_path < 4'hC |=> gen_rd_lead)
        else $error("independent path not a leader");
    irq_quiet_a: assert property ($rose(presetn) |-> !irq)
        else $error("interrupt high after reset");
endmodule

bind ppg_cfg_regs ppg_cfg_sva chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .gen_rd_path(gen_rd_path), .gen_rd_lead(gen_rd_lead),
    .gen_concat_cfg(gen_concat_cfg), .gen_concat_vec(gen_concat_vec),
    .mon_concat_cfg(mon_concat_cfg), .mon_lead_vec(mon_lead_vec),
    .mon_concat_vec(mon_concat_vec));

// >>> testbench/tb_top.sv
/*
 * Self-checking bench for ppg_cfg_regs: APB master, event stimulus and
 * an integer model of registers, flags and path grouping.
 * Assumes the design files and ppg_cfg.svh are compiled first.
 */
`timescale 1ns/10ps

module tb_top
    import ppg_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] gen_rd_path = 4'h0;
    ppg_lfsr_upd_t gen_upd = '0;
    logic [11:0] mon_sync = 12'h000;
    logic [11:0] mon_byte_err = 12'h000;
    logic pready, pslverr, irq, gen_rd_lead, perr;
    logic [31:0] prdata, rd;
    logic [22:0] gen_rd_state;
    ppg_concat_cfg_t gen_concat_cfg, mon_concat_cfg;
    logic [11:0] gen_concat_vec, mon_lead_vec, mon_concat_vec;
    logic [31:0] seed = 32'h00000040;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int lfsr_m [12];
    logic [9:0] regs [6] = '{10'h082, 10'h083, 10'h084, 10'h085, 10'h089,
        10'h08A};
    logic [15:0] cfg_tab [4] = '{16'h0000, 16'h4000, 16'h000F, 16'h4005};

    ppg_cfg_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
        .gen_rd_path(gen_rd_path), .gen_rd_state(gen_rd_state),
        .gen_rd_lead(gen_rd_lead), .gen_upd(gen_upd),
        .gen_concat_cfg(gen_concat_cfg), .gen_concat_vec(gen_concat_vec),
        .mon_concat_cfg(mon_concat_cfg), .mon_lead_vec(mon_lead_vec),
        .mon_concat_vec(mon_concat_vec), .mon_sync(mon_sync),
        .mon_byte_err(mon_byte_err));

    always #25 pclk = ~pclk;

    // ============================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Grouping model: lead selects the leader vector, else membership
    function automatic logic [11:0] vec_m(input int cfg, input bit lead);
        logic [11:0] v;
        int full;
        int grp;
        full = (cfg >> 14) & 1;
        v = 12'h000;
        for (int p = 0; p < 12; p++)
        begin
            grp = (cfg >> (p % 4)) & 1;
            if (lead)
                v[p] = full ? (p == 0) : (grp ? (p < 4) : 1'b1);
            else
                v[p] = full | grp;
        end
        return v;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [9:0] idx,
        input logic [15:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 16'h0000);
        chk({perr, rd}, {1'b0, exp});
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A hung handshake ends the run as a failure
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    // ============================================================
    // Main sequence
    initial
    begin
        logic [31:0] v;
        logic [31:0] e;
        logic [22:0] s;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rdchk(regs[i], 32'h00000000);
        for (int i = 0; i < 8; i++)
        begin
            // Random settings keep every reserved bit at zero
            v = (i < 4) ? {16'h0000, cfg_tab[i]} :
                (rnd() & 32'h0000400F);
            apb(1'b1, 10'h082, v[15:0]);
            apb(1'b1, 10'h083, v[15:0] ^ 16'h000F);
            rdchk(10'h082, v);
            rdchk(10'h083, v ^ 32'h0000000F);
            chk(gen_concat_vec, vec_m(v, 1'b0));
            chk(mon_concat_vec, vec_m(v ^ 32'h0000000F, 1'b0));
            chk(mon_lead_vec, vec_m(v ^ 32'h0000000F, 1'b1));
            e = {v[14], v[3:0], v[14], ~v[3:0]};
            chk({gen_concat_cfg, mon_concat_cfg}, e);
        end
        apb(1'b1, 10'h082, 16'h0000);
        for (int p = 0; p < 12; p++)
        begin
            lfsr_m[p] = rnd() & 32'h007FFFFF;
            s = lfsr_m[p];
            apb(1'b1, 10'h080, {8'h00, 4'(p), 4'h9});
            apb(1'b1, 10'h081, s[22:7]);
            apb(1'b1, 10'h080, {8'h00, 4'(p), 4'hA});
            apb(1'b1, 10'h081, {9'h1FF, s[6:0]});
            rdchk(10'h081, {25'h0000000, s[6:0]});
            apb(1'b1, 10'h080, {8'h00, 4'(p), 4'h9});
            rdchk(10'h081, {16'h0000, s[22:7]});
        end
        for (int p = 0; p < 12; p++)
        begin
            gen_rd_path <= 4'(p);
            tick(2);
            s = lfsr_m[p];
            chk({gen_rd_lead, gen_rd_state}, {1'b1, s});
        end
        apb(1'b1, 10'h082, 16'h4000);
        gen_rd_path <= 4'h7;
        tick(2);
        s = lfsr_m[0];
        chk({gen_rd_lead, gen_rd_state}, {1'b0, s});
        apb(1'b1, 10'h082, 16'h0002);
        gen_rd_path <= 4'h9;
        tick(2);
        s = lfsr_m[1];
        chk({gen_rd_lead, gen_rd_state}, {1'b0, s});
        gen_upd <= '{1'b1, 4'h3, 23'h2A5A5A};
        tick(1);
        gen_upd.valid <= 1'b0;
        apb(1'b1, 10'h080, 16'h003A);
        rdchk(10'h081, 32'h0000005A);
        apb(1'b1, 10'h080, 16'h00C9);
        rdchk(10'h081, 32'h00000000);
        // Events: only in-sync paths may flag byte errors
        mon_sync <= 12'h0F0;
        tick(2);
        rdchk(10'h089, 32'h000000F0);
        rdchk(10'h089, 32'h00000000);
        // One in-sync path always errs, so the enabled interrupt must rise
        e = (rnd() & 32'h00000FFF) | 32'h00000010;
        mon_byte_err <= e[11:0];
        tick(1);
        mon_byte_err <= 12'h000;
        tick(2);
        chk(irq, 1'b0);
        apb(1'b1, 10'h085, 16'h00F0);
        tick(1);
        chk(irq, |(e & 32'h000000F0));
        rdchk(10'h084, e & 32'h000000F0);
        tick(1);
        chk(irq, 1'b0);
        rdchk(10'h084, 32'h00000000);
        apb(1'b1, 10'h08A, 16'h0001);
        mon_sync <= 12'h0F1;
        tick(2);
        chk(irq, 1'b1);
        rdchk(10'h089, 32'h00000001);
        tick(1);
        chk(irq, 1'b0); // after the rising change is read
        // The falling change must flag as well
        mon_sync <= 12'h0F0;
        tick(2);
        chk(irq, 1'b1);
        rdchk(10'h089, 32'h00000001);
        apb(1'b1, 10'h086, 16'hFFFF);
        apb(1'b0, 10'h086, 16'h0000);
        chk({perr, rd}, {1'b1, 32'h00000000});
        end_of_test();
    end
endmodule
